// ==== hw/phd_sequencer.sv ====
// peak-then-hold drive sequencer with serial configuration port
//
// Contract
// R1: a drive event runs only while permit and control are both high.
// R2: the dwell time base input acts as a clock or as a level per a bit.
// R3: in clock mode the peak phase turns to hold when the dwell expires.
// R4: in level mode the phase follows the time base input with no timer.
// R5: a drop of permit or control ends the event and turns both drives off.
// R6: overcurrent pulls the fault output low after its blanking time.
// R7: antisaturation on either switch pulls fault low after its blanking.
// R8: auxiliary bit 5 picks the high-side antisaturation threshold.
// R9: auxiliary bit 4 picks the freewheel antisaturation threshold.
// R10: current levels and dwell arrive as 16-bit serial register writes.
// R11: the host leaves chip select high at least 1 us between frames.
// R12: in level mode a low input means peak and a high input means hold.
// R13: the host gives exactly 16 clocks per frame and nothing checks it.
// R14: each word splits into an address byte and a data byte written.
// R15: high side goes off before freewheel goes on, and the reverse.
// R16: the dwell counter restarts from zero at every new event.
module phd_sequencer
  import phd_pkg::*;
(
  // clock and reset
  input  wire logic             CLK,
  input  wire logic             RST_N,
  // drive request and time base
  input  wire logic             DRIVE_PERMIT,
  input  wire logic             CONTROL,
  input  wire logic             PCLK,
  // serial port
  input  wire logic             SCLK,
  input  wire logic             CSB_N,
  input  wire logic             SI,
  output logic                  SO,
  // current comparators and fault detectors
  input  wire logic             CUR_AT_HI,
  input  wire logic             CUR_AT_LO,
  input  wire logic             OC_DET,
  input  wire logic             HS_AS_DET,
  input  wire logic             FW_AS_DET,
  // predrive and loop outputs
  output logic                  GATE_DRV,
  output logic                  CLAMP_DRV,
  output logic                  LOOP_HOLD,
  output logic [LVL_W-1:0]      REF_HI,
  output logic [LVL_W-1:0]      REF_LO,
  // analog threshold selects and overvoltage enable
  output logic                  HS_AS_THR_SEL,
  output logic                  FW_AS_THR_SEL,
  output logic                  OV_IRQ_EN,
  // open-drain fault pin
  output logic                  FAULT_O,
  output logic                  FAULT_OE
);

  localparam int SYNC_W = 9;
  localparam logic [BLANK_W-1:0] OC_LIM = BLANK_W'(OC_BLANK_CYC);
  localparam logic [BLANK_W-1:0] AS_LIM = BLANK_W'(AS_BLANK_CYC);

  phd_link_if link ();

  // serial front end on its own clock
  phd_spi_rx u_rx (
    .sclk  (SCLK),
    .csb_n (CSB_N),
    .si    (SI),
    .so    (SO),
    .rst_n (RST_N),
    .bus   (link.rx)
  );

  // ---- input synchronisers ----
  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic              pclk_d_q;
  logic              permit_s;
  logic              control_s;
  logic              pclk_s;
  logic              at_hi_s;
  logic              at_lo_s;
  logic              oc_s;
  logic              hs_as_s;
  logic              fw_as_s;
  logic              csb_s;

  // two flops on every pin input except the serial clock, serial data and reset before use
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {DRIVE_PERMIT, CONTROL, PCLK, CUR_AT_HI, CUR_AT_LO,
               OC_DET, HS_AS_DET, FW_AS_DET, CSB_N};
      s2_q <= s1_q;
    end
  end

  assign permit_s  = s2_q[8];
  assign control_s = s2_q[7];
  assign pclk_s    = s2_q[6];
  assign at_hi_s   = s2_q[5];
  assign at_lo_s   = s2_q[4];
  assign oc_s      = s2_q[3];
  assign hs_as_s   = s2_q[2];
  assign fw_as_s   = s2_q[1];
  assign csb_s     = s2_q[0];

  // delayed time base for edge detection
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pclk_d_q <= 1'b0;
    end else begin
      pclk_d_q <= pclk_s;
    end
  end

  // ---- frame arrival crossing ----
  logic       t1_q;
  logic       t2_q;
  logic       t3_q;
  logic       word_new;
  logic [7:0] addr_b;
  logic [7:0] data_b;

  // toggle from the serial domain, two flops then an edge flop
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      t1_q <= 1'b0;
      t2_q <= 1'b0;
      t3_q <= 1'b0;
    end else begin
      t1_q <= link.word_tgl;
      t2_q <= t1_q;
      t3_q <= t2_q;
    end
  end

  assign word_new = t2_q ^ t3_q;
  // word is stable here: it was written on the same serial edge as the toggle
  assign addr_b   = link.word[ADDR_MSB:ADDR_LSB];  // [R14]
  assign data_b   = link.word[DATA_MSB:0];         // [R14]

  // ---- configuration registers ----
  logic [7:0]       aux_q;
  logic [LVL_W-1:0] peak_hi_q;
  logic [LVL_W-1:0] peak_lo_q;
  logic [LVL_W-1:0] hold_hi_q;
  logic [LVL_W-1:0] hold_lo_q;
  logic [7:0]       dwell_q;

  // one word may land in several registers at once
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aux_q     <= REG_RST;
      peak_hi_q <= REG_RST[LVL_W-1:0];
      peak_lo_q <= REG_RST[LVL_W-1:0];
      hold_hi_q <= REG_RST[LVL_W-1:0];
      hold_lo_q <= REG_RST[LVL_W-1:0];
      dwell_q   <= REG_RST;
    end else if (word_new) begin  // [R10]
      if (phd_hit(addr_b, A_AUX)) begin
        aux_q <= data_b;  // [R14]
      end
      if (phd_hit(addr_b, A_PEAK_HI)) begin
        peak_hi_q <= data_b[LVL_W-1:0];
      end
      if (phd_hit(addr_b, A_PEAK_LO)) begin
        peak_lo_q <= data_b[LVL_W-1:0];
      end
      if (phd_hit(addr_b, A_HOLD_HI)) begin
        hold_hi_q <= data_b[LVL_W-1:0];
      end
      if (phd_hit(addr_b, A_HOLD_LO)) begin
        hold_lo_q <= data_b[LVL_W-1:0];
      end
      if (phd_hit(addr_b, A_DWELL)) begin
        dwell_q <= data_b;
      end
    end
  end

  // ---- event and dwell timing ----
  logic             active;
  logic             active_d_q;
  logic             ev_start;
  logic             lvl_mode;
  logic [2:0]       pre_sel;
  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] pre_top;
  logic             pclk_rise;
  logic             tick;
  logic [7:0]       dwell_cnt_q;
  logic             expired_q;
  logic             hold_sel;

  assign active    = permit_s & control_s;  // [R1]
  assign ev_start  = active & ~active_d_q;
  assign lvl_mode  = aux_q[AUX_LVL_MODE];   // [R2]
  assign pre_sel   = aux_q[AUX_PRE_MSB:0];
  assign pclk_rise = pclk_s & ~pclk_d_q;
  assign pre_top   = PRE_W'((8'h01 << pre_sel) - 8'h01);
  assign tick      = pclk_rise && (pre_q == pre_top);

  // remembers whether the event was already running
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      active_d_q <= 1'b0;
    end else begin
      active_d_q <= active;
    end
  end

  // prescaler divides the time base clock by a power of two
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pre_q <= '0;
    end else if (ev_start || lvl_mode) begin
      pre_q <= '0;  // [R16]
    end else if (pclk_rise) begin
      pre_q <= (pre_q == pre_top) ? '0 : pre_q + 7'h01;
    end
  end

  // dwell counter of prescaled ticks, restarted per event
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dwell_cnt_q <= '0;
      expired_q   <= 1'b0;
    end else if (ev_start) begin
      dwell_cnt_q <= '0;  // [R16]
      expired_q   <= (dwell_q == 8'h00);
    end else if (active && !lvl_mode && !expired_q) begin
      if (dwell_cnt_q >= dwell_q) begin
        expired_q <= 1'b1;  // [R3]
      end else if (tick) begin
        dwell_cnt_q <= dwell_cnt_q + 8'h01;  // [R3]
      end
    end
  end

  // phase: level mode follows the pin, clock mode follows the timer
  assign hold_sel = lvl_mode ? pclk_s : expired_q;  // [R4] [R12]

  // ---- fault blanking ----
  logic [BLANK_W-1:0] oc_cnt_q;
  logic [BLANK_W-1:0] hs_cnt_q;
  logic [BLANK_W-1:0] fw_cnt_q;
  logic [2:0]         flt_q;
  logic [2:0]         flt_set;
  logic               faulted;
  phd_drv_t           st_q;
  phd_drv_t           st_d;

  // detectors must persist through their blanking window
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      oc_cnt_q <= '0;
      hs_cnt_q <= '0;
      fw_cnt_q <= '0;
    end else begin
      oc_cnt_q <= phd_blank(oc_cnt_q, oc_s, OC_LIM);  // [R6]
      hs_cnt_q <= phd_blank(hs_cnt_q, hs_as_s && st_q == ST_GATE,
                            AS_LIM);  // [R7]
      fw_cnt_q <= phd_blank(fw_cnt_q, fw_as_s && st_q == ST_CLAMP,
                            AS_LIM);  // [R7]
    end
  end

  assign flt_set[FLT_OC]    = (oc_cnt_q == OC_LIM);  // [R6]
  assign flt_set[FLT_HS_AS] = (hs_cnt_q == AS_LIM);  // [R7]
  assign flt_set[FLT_FW_AS] = (fw_cnt_q == AS_LIM);  // [R7]
  assign faulted            = (flt_q != 3'h0);

  // sticky flags, cleared by a completed frame; a new fault wins
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      flt_q <= 3'h0;
    end else begin
      flt_q <= (word_new ? 3'h0 : flt_q) | flt_set;
    end
  end

  // fault word for the next frame, frozen while chip select is low
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      link.snap <= '0;
    end else if (csb_s) begin
      link.snap <= {13'h0000, flt_q};
    end
  end

  // ---- predrive sequencing ----
  // a dead state sits between every switch-over
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (active && !faulted) begin
          st_d = ST_GATE;  // [R1]
        end
      end
      ST_GATE: begin
        if (at_hi_s) begin
          st_d = ST_G2C;  // [R15]
        end
      end
      ST_G2C: begin
        st_d = ST_CLAMP;  // [R15]
      end
      ST_CLAMP: begin
        if (at_lo_s) begin
          st_d = ST_C2G;  // [R15]
        end
      end
      ST_C2G: begin
        st_d = ST_GATE;  // [R15]
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    if (!active || faulted) begin
      st_d = ST_IDLE;  // [R5]
    end
  end

  // state register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // predrive outputs follow the next state
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      GATE_DRV  <= 1'b0;
      CLAMP_DRV <= 1'b0;
    end else begin
      GATE_DRV  <= (st_d == ST_GATE);   // [R5] [R15]
      CLAMP_DRV <= (st_d == ST_CLAMP);  // [R5] [R15]
    end
  end

  // reference levels for the active phase
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      REF_HI    <= '0;
      REF_LO    <= '0;
      LOOP_HOLD <= 1'b0;
    end else begin
      REF_HI    <= hold_sel ? hold_hi_q : peak_hi_q;  // [R3] [R4]
      REF_LO    <= hold_sel ? hold_lo_q : peak_lo_q;  // [R3] [R4]
      LOOP_HOLD <= hold_sel;
    end
  end

  // threshold selects and overvoltage enable from the aux register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      HS_AS_THR_SEL <= 1'b0;
      FW_AS_THR_SEL <= 1'b0;
      OV_IRQ_EN     <= 1'b0;
    end else begin
      HS_AS_THR_SEL <= aux_q[AUX_HS_THR];  // [R8]
      FW_AS_THR_SEL <= aux_q[AUX_FW_THR];  // [R9]
      OV_IRQ_EN     <= aux_q[AUX_OV_IRQ];
    end
  end

  // open-drain fault pin: drive low while any flag is latched
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      FAULT_O  <= 1'b0;
      FAULT_OE <= 1'b0;
    end else begin
      FAULT_O  <= 1'b0;
      FAULT_OE <= faulted | (flt_set != 3'h0);  // [R6] [R7]
    end
  end

endmodule // phd_sequencer

// ==== hw/phd_pkg.sv ====
// constants, types and helpers shared by the peak/hold sequencer files
package phd_pkg;

  // core clock rate and derived time counts
  localparam int CLK_MHZ       = 40;
  localparam int OC_BLANK_NS   = 2500;   // overcurrent blanking, nominal
  localparam int AS_BLANK_NS   = 10000;  // antisaturation blanking, nominal
  localparam int XFER_GAP_NS   = 1000;   // least gap between serial frames
  localparam int OC_BLANK_CYC  = (OC_BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int AS_BLANK_CYC  = (AS_BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int XFER_GAP_CYC  = (XFER_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK_W       = 9;

  // serial word layout
  localparam int WORD_W        = 16;
  localparam int ADDR_MSB      = 15;
  localparam int ADDR_LSB      = 8;
  localparam int DATA_MSB      = 7;
  localparam int BITCNT_W      = 4;
  localparam logic [BITCNT_W-1:0] BITCNT_LAST = 4'hF;

  // bit-decoded register addresses
  localparam logic [7:0] A_AUX     = 8'h01;
  localparam logic [7:0] A_HOLD_LO = 8'h02;
  localparam logic [7:0] A_HOLD_HI = 8'h04;
  localparam logic [7:0] A_PEAK_LO = 8'h08;
  localparam logic [7:0] A_PEAK_HI = 8'h10;
  localparam logic [7:0] A_DWELL   = 8'h20;
  localparam logic [7:0] A_TEST    = 8'hC0;
  localparam logic [7:0] REG_RST   = 8'h00;

  // auxiliary register fields
  localparam int AUX_OV_IRQ    = 6;
  localparam int AUX_HS_THR    = 5;
  localparam int AUX_FW_THR    = 4;
  localparam int AUX_LVL_MODE  = 3;
  localparam int AUX_PRE_MSB   = 2;
  localparam int LVL_W         = 7;
  localparam int PRE_W         = 7;

  // fault word bit positions
  localparam int FLT_OC        = 0;
  localparam int FLT_HS_AS     = 1;
  localparam int FLT_FW_AS     = 2;

  // predrive sequencing states
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b0_0001,
    ST_GATE  = 5'b0_0010,
    ST_G2C   = 5'b0_0100,
    ST_CLAMP = 5'b0_1000,
    ST_C2G   = 5'b1_0000
  } phd_drv_t;

  // address byte hits a register when its bit is set and no test bit is
  function automatic logic phd_hit(input logic [7:0] addr,
                                   input logic [7:0] mask);
    phd_hit = ((addr & mask) != 8'h00) && ((addr & A_TEST) == 8'h00);
  endfunction

  // blanking counter step: counts while the condition holds, saturates
  function automatic logic [BLANK_W-1:0] phd_blank(
      input logic [BLANK_W-1:0] cnt, input logic cond,
      input logic [BLANK_W-1:0] lim);
    if (!cond) begin
      phd_blank = '0;
    end else if (cnt >= lim) begin
      phd_blank = lim;
    end else begin
      phd_blank = cnt + 9'h001;
    end
  endfunction

endpackage : phd_pkg

// ==== hw/phd_link_if.sv ====
// carrier between the serial front end and the sequencer core
interface phd_link_if;
  import phd_pkg::*;
  logic              word_tgl;  // toggles once per complete frame
  logic [WORD_W-1:0] word;      // last received command word
  logic [WORD_W-1:0] snap;      // fault word, frozen while a frame runs

  modport rx   (output word_tgl, output word, input snap);
  modport core (input word_tgl, input word, output snap);
endinterface : phd_link_if

// ==== hw/phd_spi_rx.sv ====
// serial front end running on the serial clock
module phd_spi_rx
  import phd_pkg::*;
(
  // serial link
  input  wire logic sclk,
  input  wire logic csb_n,
  input  wire logic si,
  output logic      so,
  // reset
  input  wire logic rst_n,
  // core side
  phd_link_if.rx    bus
);

  logic [BITCNT_W-1:0] cnt_q;
  logic [WORD_W-1:0]   shift_q;
  logic [WORD_W-1:0]   word_q;
  logic                tgl_q;
  logic                so_q;

  // bit counter, cleared whenever the frame is closed
  always_ff @(posedge sclk or posedge csb_n) begin
    if (csb_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // msb-first capture on rising edges
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= '0;
    end else begin
      shift_q <= {shift_q[WORD_W-2:0], si};
    end
  end

  // sixteenth bit completes the word and signals the core
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      word_q <= '0;
      tgl_q  <= 1'b0;
    end else if (!csb_n && cnt_q == BITCNT_LAST) begin
      word_q <= {shift_q[WORD_W-2:0], si};
      tgl_q  <= ~tgl_q;
    end
  end

  // fault bits change on falling edges, next bit after the msb
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      so_q <= 1'b0;
    end else begin
      so_q <= bus.snap[BITCNT_LAST - cnt_q];
    end
  end

  // msb stands from frame start until the first rising edge
  assign so           = (cnt_q == '0) ? bus.snap[WORD_W-1] : so_q;
  assign bus.word     = word_q;
  assign bus.word_tgl = tgl_q;

endmodule // phd_spi_rx

// ==== verification/phd_seq_chk.sv ====
// concurrent checks on the peak/hold sequencer top ports
module phd_seq_chk (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // drive request and detectors
  input wire logic DRIVE_PERMIT,
  input wire logic CONTROL,
  input wire logic CUR_AT_HI,
  input wire logic CUR_AT_LO,
  input wire logic OC_DET,
  input wire logic HS_AS_DET,
  input wire logic FW_AS_DET,
  // watched outputs
  input wire logic GATE_DRV,
  input wire logic CLAMP_DRV,
  input wire logic FAULT_O,
  input wire logic FAULT_OE
);
  logic       act;
  logic       as_run;
  logic [7:0] oc_cnt_q;
  logic [9:0] as_cnt_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // request level and a running antisaturation condition on the live switch
  assign act    = DRIVE_PERMIT && CONTROL;
  assign as_run = act && (
      (HS_AS_DET && !CUR_AT_HI && (as_cnt_q != 10'h000 || GATE_DRV)) ||
      (FW_AS_DET && !CUR_AT_LO && (as_cnt_q != 10'h000 || CLAMP_DRV)));

  // saturating run-length counters of the two fault conditions
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      oc_cnt_q <= 8'h00;
      as_cnt_q <= 10'h000;
    end else begin
      oc_cnt_q <= !OC_DET ? 8'h00 : oc_cnt_q + {7'h00, oc_cnt_q != 8'hFF};
      as_cnt_q <= !as_run ? 10'h000 : as_cnt_q + {9'h000, as_cnt_q != 10'h3FF};
    end
  end

  sequence s_start;
    $rose(act) ##1 (act && !FAULT_OE && !CUR_AT_HI) [*4];
  endsequence
  property p_start;
    s_start |-> GATE_DRV;
  endproperty
  a_start: assert property (p_start)
    else $error("gate not on after request");

  property p_drop;
    (!act) [*4] |-> !GATE_DRV && !CLAMP_DRV;
  endproperty
  a_drop: assert property (p_drop)
    else $error("drive left on after drop");

  property p_dead;
    (GATE_DRV |=> !CLAMP_DRV) and (CLAMP_DRV |=> !GATE_DRV);
  endproperty
  a_dead: assert property (p_dead)
    else $error("no dead cycle between drives");

  sequence s_oc_rise;
    $rose(OC_DET) && !FAULT_OE && !HS_AS_DET && !FW_AS_DET;
  endsequence
  property p_oc_early;
    s_oc_rise |-> ##49 !FAULT_OE;
  endproperty
  a_oc_early: assert property (p_oc_early)
    else $error("oc fault too early");

  // 0xC8 is 200 cycles, the longest overcurrent blanking
  property p_oc_late;
    oc_cnt_q == 8'hC8 |-> FAULT_OE;
  endproperty
  a_oc_late: assert property (p_oc_late)
    else $error("oc fault too late");

  // 0x320 is 800 cycles, the longest antisaturation blanking
  property p_as_late;
    as_cnt_q == 10'h320 |-> FAULT_OE;
  endproperty
  a_as_late: assert property (p_as_late)
    else $error("antisat fault too late");

  property p_pin_low;
    FAULT_OE |-> !FAULT_O;
  endproperty
  a_pin_low: assert property (p_pin_low)
    else $error("fault pin not low");

  property p_fault_stop;
    FAULT_OE [*3] |-> !GATE_DRV && !CLAMP_DRV;
  endproperty
  a_fault_stop: assert property (p_fault_stop)
    else $error("drive on in fault");
endmodule // phd_seq_chk

bind phd_sequencer phd_seq_chk phd_seq_chk_inst (
  .CLK(CLK), .RST_N(RST_N), .DRIVE_PERMIT(DRIVE_PERMIT), .CONTROL(CONTROL),
  .CUR_AT_HI(CUR_AT_HI), .CUR_AT_LO(CUR_AT_LO), .OC_DET(OC_DET),
  .HS_AS_DET(HS_AS_DET), .FW_AS_DET(FW_AS_DET), .GATE_DRV(GATE_DRV),
  .CLAMP_DRV(CLAMP_DRV), .FAULT_O(FAULT_O), .FAULT_OE(FAULT_OE)
);

// ==== verification/phd_host_model.sv ====
// serial host model that frames command words into the sequencer
module phd_host_model (
  // serial link toward the device
  output logic      SCLK,
  output logic      CSB_N,
  output logic      SI,
  // fault word coming back
  input  wire logic SO
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle: select high, clock parked low
  initial begin
    SCLK  = 1'b0;
    CSB_N = 1'b1;
    SI    = 1'b0;
  end

  // one frame: gap, select, sixteen clocks msb first, deselect
  task automatic send(input logic [15:0] w, output logic [15:0] r);
    #1000;                              // select stays high a full gap
    CSB_N = 1'b0;
    #64;
    for (int i = 15; i >= 0; i--) begin // exactly sixteen clocks
      SI = w[i];
      #16 SCLK = 1'b1;
      r[i] = SO;
      #16 SCLK = 1'b0;
    end
    SI = ~SI;                           // released line shows no stale bit
    #80 CSB_N = 1'b1;
  endtask
endmodule // phd_host_model

// ==== verification/test_phd_sequencer.sv ====
// self-checking bench for the peak/hold sequencer
module test_phd_sequencer;
  timeunit 1ns;
  timeprecision 1ps;

  logic        CLK, RST_N, DRIVE_PERMIT, CONTROL, PCLK, SCLK, CSB_N, SI, SO;
  logic        CUR_AT_HI, CUR_AT_LO, OC_DET, HS_AS_DET, FW_AS_DET;
  logic        GATE_DRV, CLAMP_DRV, LOOP_HOLD, HS_AS_THR_SEL, FW_AS_THR_SEL;
  logic        OV_IRQ_EN, FAULT_O, FAULT_OE;
  logic [6:0]  REF_HI, REF_LO;
  logic [15:0] rx;
  int          error_cnt = 0;
  int          n_checks = 0;

  phd_sequencer phd_sequencer_inst (.*);
  phd_host_model phd_host_model_inst (.*);

  // core clock, 25 ns
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  task automatic step(input int n);
    repeat (n) @(posedge CLK);
    #2;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // one register write, then let it land
  task automatic wr(input logic [15:0] w);
    phd_host_model_inst.send(w, rx);
    step(8);
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      PCLK = 1'b1;
      step(6);
      PCLK = 1'b0;
      step(6);
    end
  endtask

  // aux bits, refused test address and multi-register writes
  task automatic t_regs();
    wr(16'h0170);
    chk(16'({OV_IRQ_EN, HS_AS_THR_SEL, FW_AS_THR_SEL}), 16'h0007);
    wr(16'h8100);
    chk(16'({OV_IRQ_EN, HS_AS_THR_SEL, FW_AS_THR_SEL}), 16'h0007);
    wr(16'h0120);
    chk(16'({OV_IRQ_EN, HS_AS_THR_SEL, FW_AS_THR_SEL}), 16'h0002);
    wr(16'h0110);
    chk(16'({OV_IRQ_EN, HS_AS_THR_SEL, FW_AS_THR_SEL}), 16'h0001);
    wr(16'h0100);
    wr(16'h1855);
    wr(16'h0622);
    wr(16'h2003);
    chk(16'({REF_HI, REF_LO}), 16'h2AD5);
  endtask

  // clock-mode dwell, switching, early end and restart of the count
  task automatic t_drive();
    DRIVE_PERMIT = 1'b1;
    CONTROL = 1'b1;
    step(5);
    chk(16'({GATE_DRV, CLAMP_DRV}), 16'h0002);
    CUR_AT_HI = 1'b1;
    step(6);
    CUR_AT_HI = 1'b0;
    chk(16'({GATE_DRV, CLAMP_DRV}), 16'h0001);
    CUR_AT_LO = 1'b1;
    step(6);
    CUR_AT_LO = 1'b0;
    chk(16'({GATE_DRV, CLAMP_DRV}), 16'h0002);
    pulses(2);
    CONTROL = 1'b0;
    step(5);
    chk(16'({GATE_DRV, CLAMP_DRV}), 16'h0000);
    CONTROL = 1'b1;
    step(4);
    pulses(2);
    chk(16'(LOOP_HOLD), 16'h0000);
    pulses(1);
    chk(16'({LOOP_HOLD, REF_HI, REF_LO}), 16'h5122);
    CONTROL = 1'b0;
    DRIVE_PERMIT = 1'b0;
    step(5);
  endtask

  // level mode: low input gives peak, high gives hold
  task automatic t_level();
    wr(16'h0108);
    DRIVE_PERMIT = 1'b1;
    CONTROL = 1'b1;
    for (int v = 0; v < 3; v++) begin
      PCLK = v[0];
      step(6);
      chk(16'({LOOP_HOLD, REF_HI}), v[0] ? 16'h00A2 : 16'h0055);
    end
    CONTROL = 1'b0;
    DRIVE_PERMIT = 1'b0;
    wr(16'h0100);
  endtask

  // overcurrent blanking window, fault word and clear by a frame
  task automatic t_oc();
    OC_DET = 1'b1;
    step(45);
    chk(16'(FAULT_OE), 16'h0000);
    step(160);
    chk(16'({FAULT_OE, FAULT_O}), 16'h0002);
    OC_DET = 1'b0;
    wr(16'h0000);
    chk(rx, 16'h0001);
    chk(16'(FAULT_OE), 16'h0000);
  endtask

  // antisaturation on the high side or on the freewheel switch
  task automatic t_as(input logic fw);
    DRIVE_PERMIT = 1'b1;
    CONTROL = 1'b1;
    step(5);
    if (fw) begin
      CUR_AT_HI = 1'b1;
      step(6);
      CUR_AT_HI = 1'b0;
    end
    HS_AS_DET = !fw;
    FW_AS_DET = fw;
    step(190);
    chk(16'(FAULT_OE), 16'h0000);
    step(620);
    chk(16'({FAULT_OE, GATE_DRV, CLAMP_DRV}), 16'h0004);
    HS_AS_DET = 1'b0;
    FW_AS_DET = 1'b0;
    CONTROL = 1'b0;
    DRIVE_PERMIT = 1'b0;
    wr(16'h0000);
    chk(rx, fw ? 16'h0004 : 16'h0002);
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    {DRIVE_PERMIT, CONTROL, PCLK, CUR_AT_HI, CUR_AT_LO} = 5'h00;
    {OC_DET, HS_AS_DET, FW_AS_DET} = 3'h0;
    RST_N = 1'b0;
    step(10);
    RST_N = 1'b1;
    step(2);
    t_regs();
    t_drive();
    t_level();
    t_oc();
    t_as(1'b0);
    t_as(1'b1);
    tally_and_finish();
  end

  // watchdog against a hang
  initial begin
    #400000;
    error_cnt++;
    tally_and_finish();
  end
endmodule // test_phd_sequencer
